// *** nfctr_pkg.sv ***
// nfctr_pkg: constants, types and functional notes for the tag response register bank
// ---------------------------------------------------------------------------
// Functional notes
// - file_offset is a 16-bit read-write register for the pending read or update command, high byte 15-8, low byte 7-0, reset to zero.
// - on an update command the device loads buffer_start_index with the buffer index where it began storing the received packet.
// - buffer_start_index is 16 bits, high byte 15-8, low byte 7-0, both read-write and reset to zero.
// - the device answers each reader command within the frame wait time set by FWI, and sends an S(WTX) request when it cannot.
// - the reader's S(WTX) response restarts the response time-out.
// - the INF field of an S(WTX) request carries wait_extension_byte, bits 7-0 of wait_extension_request.
// - wait_extension_byte resets to 1; bits 15-8 are reserved read-write, reset to zero, and written as zero by software.
// - by default Select, Read Binary and Update Binary are answered with the device's predefined status words.
// - while custom_status_enable is set those commands are answered with custom_status_word.
// - custom_status_word holds SW1 in bits 15-8 and SW2 in bits 7-0, both read-write, reset to zero.
// - the device has no boundary scan test access.
// - the software version number is readable by the host through a version register.
// ---------------------------------------------------------------------------
package nfctr_pkg;

  // -------------------------------------------------------------------------
  // register byte addresses
  // -------------------------------------------------------------------------
  localparam logic [15:0] ADDR_CSW_LO    = 16'hffda;
  localparam logic [15:0] ADDR_CSW_HI    = 16'hffdb;
  localparam logic [15:0] ADDR_WTX_LO    = 16'hffde;
  localparam logic [15:0] ADDR_WTX_HI    = 16'hffdf;
  localparam logic [15:0] ADDR_BUF_LO    = 16'hffe4;
  localparam logic [15:0] ADDR_BUF_HI    = 16'hffe5;
  localparam logic [15:0] ADDR_OFS_LO    = 16'hffe6;
  localparam logic [15:0] ADDR_OFS_HI    = 16'hffe7;
  localparam logic [15:0] ADDR_VER_LO    = 16'hffea;

  // -------------------------------------------------------------------------
  // reset values and read answers
  // -------------------------------------------------------------------------
  localparam logic [15:0] RST_CSW        = 16'h0000;
  localparam logic [15:0] RST_WTX        = 16'h0001;
  localparam logic [15:0] RST_BUF        = 16'h0000;
  localparam logic [15:0] RST_OFS        = 16'h0000;
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
  // arbitrary neutral value, not any real release
  localparam logic [15:0] VERSION_DEFAULT = 16'h0100;

  // -------------------------------------------------------------------------
  // frame wait time: 4096 carrier periods times 2^fwi
  // -------------------------------------------------------------------------
  localparam int          FWT_CARRIER_PERIODS = 4096;
  localparam int          CARRIER_KHZ         = 13560;
  localparam int          CLK_KHZ             = 125000;
  // shortest time, so the division rounds down
  localparam int          FWT_BASE_CYCLES     = FWT_CARRIER_PERIODS * CLK_KHZ / CARRIER_KHZ;
  localparam logic [3:0]  FWI_MAX             = 4'he;
  // wtx is asked for once a quarter of the wait time remains
  localparam int          WTX_MARGIN_SHIFT    = 2;
  localparam int          TIMER_W             = 32;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } nfctr_reg_req_type;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
  } nfctr_reg_rsp_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } nfctr_sw_type;

  typedef enum logic [1:0] {
    WT_IDLE = 2'b00,
    WT_RUN  = 2'b01,
    WT_WTX  = 2'b10
  } nfctr_wt_state_type;

endpackage

// *** nfctr_wait_timer.sv ***
// nfctr_wait_timer: frame wait timer that asks for a wait time extension
module nfctr_wait_timer #(
  parameter int FWT_BASE_CYCLES = nfctr_pkg::FWT_BASE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // command progress
  input  wire logic       cmd_start,
  input  wire logic       rsp_done,
  input  wire logic       wtx_ack,
  input  wire logic [3:0] fwi,
  input  wire logic [7:0] wtx_byte,
  // extension request
  output logic            wtx_req,
  output logic [7:0]      wtx_inf,
  output logic            timer_busy
);
  import nfctr_pkg::*;

  if (FWT_BASE_CYCLES < 4) begin : g_base_small
    $error("FWT_BASE_CYCLES too small");
  end
  if (FWT_BASE_CYCLES > 32'h0003_ffff) begin : g_base_large
    $error("FWT_BASE_CYCLES overflows the timer");
  end

  nfctr_wt_state_type       state;
  logic [TIMER_W-1:0]       elapsed;
  logic [TIMER_W-1:0]       limit;
  logic [TIMER_W-1:0]       fwt;
  logic [3:0]               fwi_eff;

  // fwi 15 is reserved, treat it as the largest legal value
  assign fwi_eff = (fwi > FWI_MAX) ? FWI_MAX : fwi;
  assign fwt     = TIMER_W'(FWT_BASE_CYCLES) << fwi_eff;

  // -------------------------------------------------------------------------
  // state and timer
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= WT_IDLE;
      elapsed <= '0;
      limit   <= '0;
    end else begin
      case (state)
        WT_IDLE: begin
          if (cmd_start) begin
            elapsed <= '0;
            limit   <= fwt - (fwt >> WTX_MARGIN_SHIFT);
            state   <= WT_RUN;
          end
        end
        WT_RUN: begin
          if (rsp_done) begin
            state <= WT_IDLE;
          end else if (elapsed >= limit) begin
            state <= WT_WTX;
          end else begin
            elapsed <= elapsed + TIMER_W'(1);
          end
        end
        WT_WTX: begin
          if (rsp_done) begin
            state <= WT_IDLE;
          end else if (wtx_ack) begin
            elapsed <= '0;
            state   <= WT_RUN;
          end
        end
        default: state <= WT_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // extension request pulse with its inf byte
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wtx_req <= 1'b0;
      wtx_inf <= 8'h00;
    end else begin
      wtx_req <= (state == WT_RUN) && !rsp_done && (elapsed >= limit);
      if ((state == WT_RUN) && !rsp_done && (elapsed >= limit)) begin
        wtx_inf <= wtx_byte;
      end
    end
  end

  assign timer_busy = (state != WT_IDLE);

endmodule // nfctr_wait_timer

// *** nfctr_regs.sv ***
// nfctr_regs: host response register bank of the type 4 tag with status word and wtx control
module nfctr_regs #(
  parameter int          FWT_BASE_CYCLES = nfctr_pkg::FWT_BASE_CYCLES,
  parameter logic [15:0] VERSION_ADDR    = nfctr_pkg::ADDR_VER_LO,
  parameter logic [15:0] VERSION_VALUE   = nfctr_pkg::VERSION_DEFAULT
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // byte register port from the serial engine
  input  wire nfctr_pkg::nfctr_reg_req_type reg_req,
  output nfctr_pkg::nfctr_reg_rsp_type      reg_rsp,
  // host response control
  input  wire logic                       custom_status_enable,
  // command engine: offset and buffer index loads
  input  wire logic                       offset_load,
  input  wire logic [15:0]                offset_value,
  input  wire logic                       update_index_load,
  input  wire logic [15:0]                update_index,
  // command engine: status word request
  input  wire logic                       sw_req,
  input  wire logic [15:0]                sw_default,
  output nfctr_pkg::nfctr_sw_type           sw_rsp,
  // command engine: frame wait timing
  input  wire logic                       cmd_start,
  input  wire logic                       rsp_done,
  input  wire logic                       wtx_ack,
  input  wire logic [3:0]                 fwi,
  output logic                            wtx_req,
  output logic [7:0]                      wtx_inf,
  output logic                            timer_busy,
  // register contents for the command engine
  output logic [15:0]                     file_offset_out,
  output logic [15:0]                     buffer_start_out
);
  import nfctr_pkg::*;

  if (VERSION_ADDR[0] != 1'b0) begin : g_ver_odd
    $error("VERSION_ADDR must be even");
  end
  if ((VERSION_ADDR >= ADDR_CSW_LO) && (VERSION_ADDR <= ADDR_OFS_HI)) begin : g_ver_overlap
    $error("VERSION_ADDR overlaps the register bank");
  end

  // -------------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------------
  logic [15:0] custom_status_word;
  logic [15:0] wait_extension_request;
  logic [15:0] buffer_start_index;
  logic [15:0] file_offset;
  logic [7:0]  wait_extension_byte;

  // byte write strobes
  logic wr_csw_lo;
  logic wr_csw_hi;
  logic wr_wtx_lo;
  logic wr_wtx_hi;
  logic wr_buf_lo;
  logic wr_buf_hi;
  logic wr_ofs_lo;
  logic wr_ofs_hi;

  assign wr_csw_lo = reg_req.wr && (reg_req.addr == ADDR_CSW_LO);
  assign wr_csw_hi = reg_req.wr && (reg_req.addr == ADDR_CSW_HI);
  assign wr_wtx_lo = reg_req.wr && (reg_req.addr == ADDR_WTX_LO);
  assign wr_wtx_hi = reg_req.wr && (reg_req.addr == ADDR_WTX_HI);
  assign wr_buf_lo = reg_req.wr && (reg_req.addr == ADDR_BUF_LO);
  assign wr_buf_hi = reg_req.wr && (reg_req.addr == ADDR_BUF_HI);
  assign wr_ofs_lo = reg_req.wr && (reg_req.addr == ADDR_OFS_LO);
  assign wr_ofs_hi = reg_req.wr && (reg_req.addr == ADDR_OFS_HI);

  // -------------------------------------------------------------------------
  // custom status word
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      custom_status_word <= RST_CSW;
    end else begin
      if (wr_csw_hi) begin
        custom_status_word[15:8] <= reg_req.wdata;
      end
      if (wr_csw_lo) begin
        custom_status_word[7:0] <= reg_req.wdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // wait extension request
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_extension_request <= RST_WTX;
    end else begin
      // reserved byte is kept as written; software is expected to write zero
      if (wr_wtx_hi) begin
        wait_extension_request[15:8] <= reg_req.wdata;
      end
      if (wr_wtx_lo) begin
        wait_extension_request[7:0] <= reg_req.wdata;
      end
    end
  end

  assign wait_extension_byte = wait_extension_request[7:0];

  // -------------------------------------------------------------------------
  // buffer start index
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buffer_start_index <= RST_BUF;
    end else if (update_index_load) begin
      // engine load wins over a host byte write in the same cycle
      buffer_start_index <= update_index;
    end else begin
      if (wr_buf_hi) begin
        buffer_start_index[15:8] <= reg_req.wdata;
      end
      if (wr_buf_lo) begin
        buffer_start_index[7:0] <= reg_req.wdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // file offset
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_offset <= RST_OFS;
    end else if (offset_load) begin
      file_offset <= offset_value;
    end else begin
      if (wr_ofs_hi) begin
        file_offset[15:8] <= reg_req.wdata;
      end
      if (wr_ofs_lo) begin
        file_offset[7:0] <= reg_req.wdata;
      end
    end
  end

  assign file_offset_out  = file_offset;
  assign buffer_start_out = buffer_start_index;

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = UNMAPPED_DATA;
    if (reg_req.addr == VERSION_ADDR) begin
      next_rdata = VERSION_VALUE[7:0];
    end else if (reg_req.addr == (VERSION_ADDR + 16'h0001)) begin
      next_rdata = VERSION_VALUE[15:8];
    end else begin
      case (reg_req.addr)
        ADDR_CSW_LO: next_rdata = custom_status_word[7:0];
        ADDR_CSW_HI: next_rdata = custom_status_word[15:8];
        ADDR_WTX_LO: next_rdata = wait_extension_request[7:0];
        ADDR_WTX_HI: next_rdata = wait_extension_request[15:8];
        ADDR_BUF_LO: next_rdata = buffer_start_index[7:0];
        ADDR_BUF_HI: next_rdata = buffer_start_index[15:8];
        ADDR_OFS_LO: next_rdata = file_offset[7:0];
        ADDR_OFS_HI: next_rdata = file_offset[15:8];
        default:     next_rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.valid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rsp.rdata <= next_rdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // status word for select, read binary and update binary answers
  // -------------------------------------------------------------------------
  // the word is sampled once per request so a later host change cannot tear it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_rsp <= '0;
    end else begin
      sw_rsp.valid <= sw_req;
      if (sw_req) begin
        if (custom_status_enable) begin
          sw_rsp.word <= custom_status_word;
        end else begin
          sw_rsp.word <= sw_default;
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // frame wait timing
  // -------------------------------------------------------------------------
  // no boundary scan port exists on this block
  nfctr_wait_timer #(
    .FWT_BASE_CYCLES (FWT_BASE_CYCLES)
  ) u_wait_timer (
    .clk        (clk),
    .rst_b      (rst_b),
    .cmd_start  (cmd_start),
    .rsp_done   (rsp_done),
    .wtx_ack    (wtx_ack),
    .fwi        (fwi),
    .wtx_byte   (wait_extension_byte),
    .wtx_req    (wtx_req),
    .wtx_inf    (wtx_inf),
    .timer_busy (timer_busy)
  );

endmodule // nfctr_regs

// *** nfctr_regs_properties.sv ***
// nfctr_regs_properties: concurrent checks on the response register bank ports
module nfctr_regs_chk #(
  parameter int FWT_BASE_CYCLES = 8
) (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         rst_b,
  // register port
  input wire nfctr_pkg::nfctr_reg_req_type reg_req,
  input wire nfctr_pkg::nfctr_reg_rsp_type reg_rsp,
  // status word
  input wire logic                         custom_status_enable,
  input wire logic                         sw_req,
  input wire logic [15:0]                  sw_default,
  input wire nfctr_pkg::nfctr_sw_type      sw_rsp,
  // engine loads
  input wire logic                         offset_load,
  input wire logic [15:0]                  offset_value,
  input wire logic                         update_index_load,
  input wire logic [15:0]                  update_index,
  input wire logic [15:0]                  file_offset_out,
  input wire logic [15:0]                  buffer_start_out,
  // wait timer
  input wire logic                         cmd_start,
  input wire logic                         rsp_done,
  input wire logic                         wtx_req,
  input wire logic [7:0]                   wtx_inf,
  input wire logic                         timer_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import nfctr_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_read_answer: assert property (reg_req.rd |=> reg_rsp.valid)
    else $error("read strobe got no answer");
  chk_valid_cause: assert property (reg_rsp.valid |-> $past(reg_req.rd))
    else $error("read data valid without a read");
  chk_sw_answer: assert property (sw_req |=> sw_rsp.valid)
    else $error("status word request got no answer");
  chk_sw_default: assert property (sw_req && !custom_status_enable |=> sw_rsp.word == $past(sw_default))
    else $error("default status word not returned");
  chk_sw_hold: assert property (!sw_req |=> $stable(sw_rsp.word))
    else $error("status word moved without a request");
  chk_offset_load: assert property (offset_load |=> file_offset_out == $past(offset_value))
    else $error("offset load not taken");
  chk_index_load: assert property (update_index_load |=> buffer_start_out == $past(update_index))
    else $error("buffer index load not taken");
  chk_wtx_single: assert property (wtx_req |=> !wtx_req)
    else $error("extension request longer than one cycle");
  chk_wtx_busy: assert property (wtx_req |-> timer_busy)
    else $error("extension request while timer idle");
  chk_inf_hold: assert property (!wtx_req |-> $stable(wtx_inf))
    else $error("extension byte moved without a request");
  chk_done_idle: assert property (rsp_done && !cmd_start |=> !timer_busy)
    else $error("timer still busy after response");
  chk_start_busy: assert property (cmd_start && !rsp_done |=> timer_busy)
    else $error("timer not started by command");
endmodule  // nfctr_regs_chk

bind nfctr_regs nfctr_regs_chk #(.FWT_BASE_CYCLES(FWT_BASE_CYCLES)) chk_u (
  .clk, .rst_b, .reg_req, .reg_rsp, .custom_status_enable, .sw_req, .sw_default, .sw_rsp,
  .offset_load, .offset_value, .update_index_load, .update_index, .file_offset_out,
  .buffer_start_out, .cmd_start, .rsp_done, .wtx_req, .wtx_inf, .timer_busy
);

// *** nfctr_engine_model.sv ***
// nfctr_engine_model: far-side model that answers wait extension requests
module nfctr_engine_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // extension handshake
  input  wire logic       wtx_req,
  input  wire logic [3:0] ack_delay,
  output logic            wtx_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       armed;
  logic [3:0] wait_cnt;
  // a long delay plays a slow reader
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed    <= 1'b0;
      wait_cnt <= 4'h0;
      wtx_ack  <= 1'b0;
    end else begin
      wtx_ack <= 1'b0;
      if (wtx_req) begin
        armed    <= 1'b1;
        wait_cnt <= 4'h0;
      end else if (armed && wait_cnt == ack_delay) begin
        armed   <= 1'b0;
        wtx_ack <= 1'b1;
      end else if (armed) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule  // nfctr_engine_model

// *** testbench.sv ***
// testbench: self-checking bench for the response register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nfctr_pkg::*;
  localparam int BASE = 8;
  logic              clk;
  logic              rst_b;
  nfctr_reg_req_type reg_req;
  nfctr_reg_rsp_type reg_rsp;
  nfctr_sw_type      sw_rsp;
  logic              custom_status_enable, offset_load, update_index_load, sw_req;
  logic              cmd_start, rsp_done, wtx_ack, wtx_req, timer_busy;
  logic [15:0]       offset_value, update_index, sw_default, file_offset_out, buffer_start_out;
  logic [3:0]        fwi, ack_dly;
  logic [7:0]        wtx_inf, d;
  logic [7:0]        mdl [8];
  logic [15:0]       amap [8];
  logic [31:0]       seed;
  int                n_fail, num_checks, cyc, n;

  nfctr_regs #(.FWT_BASE_CYCLES(BASE)) dut_u (
    .clk, .rst_b, .reg_req, .reg_rsp, .custom_status_enable, .offset_load, .offset_value,
    .update_index_load, .update_index, .sw_req, .sw_default, .sw_rsp, .cmd_start,
    .rsp_done, .wtx_ack, .fwi, .wtx_req, .wtx_inf, .timer_busy, .file_offset_out,
    .buffer_start_out
  );
  nfctr_engine_model eng_u (.clk, .rst_b, .wtx_req, .ack_delay(ack_dly), .wtx_ack);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // cycles from the taking edge to the extension request
  function automatic int wait_len(input int f);
    return (BASE << f) - ((BASE << f) >> 2) + 1;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
    n++;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    check(reg_rsp.valid, 1'b1);
    v = reg_rsp.rdata;
  endtask

  // ---------------------------------------------------------------------
  // clock and hang guard
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 5000) begin
        n_fail++;
        report_and_stop();
      end
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 32'd32;
    n_fail = 0;
    num_checks = 0;
    rst_b = 1'b0;
    reg_req = '0;
    {custom_status_enable, offset_load, update_index_load, sw_req} = 4'h0;
    {cmd_start, rsp_done, fwi, ack_dly} = 10'h000;
    {offset_value, update_index, sw_default} = 48'h0;
    amap = '{ADDR_CSW_LO, ADDR_CSW_HI, ADDR_WTX_LO, ADDR_WTX_HI,
             ADDR_BUF_LO, ADDR_BUF_HI, ADDR_OFS_LO, ADDR_OFS_HI};
    mdl = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(amap[i], d);
      check(d, mdl[i]);
    end
    wr(ADDR_VER_LO, 8'h5a);
    rd(ADDR_VER_LO, d);
    check(d, VERSION_DEFAULT[7:0]);
    rd(ADDR_VER_LO + 16'h0001, d);
    check(d, VERSION_DEFAULT[15:8]);
    rd(16'hffd0, d);
    check(d, UNMAPPED_DATA);
    // random byte traffic; reserved byte only ever written as zero
    for (int k = 0; k < 60; k++) begin
      n = int'(rnd() % 32'd8);
      d = (n == 3) ? 8'h00 : 8'(rnd());
      wr(amap[n], d);
      mdl[n] = d;
      n = int'(rnd() % 32'd8);
      rd(amap[n], d);
      check(d, mdl[n]);
    end
    @(posedge clk);
    offset_value <= 16'(rnd());
    update_index <= 16'(rnd());
    offset_load <= 1'b1;
    update_index_load <= 1'b1;
    // a host byte write in the same cycle loses to the engine load
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_OFS_LO, wdata: 8'h5a};
    @(posedge clk);
    offset_load <= 1'b0;
    update_index_load <= 1'b0;
    reg_req <= '0;
    #1;
    check(file_offset_out, offset_value);
    check(buffer_start_out, update_index);
    rd(ADDR_BUF_HI, d);
    check(d, update_index[15:8]);
    rd(ADDR_OFS_LO, d);
    check(d, offset_value[7:0]);
    // both custom bytes are written before enabling
    wr(ADDR_CSW_HI, 8'h6a);
    wr(ADDR_CSW_LO, 8'h82);
    mdl[1] = 8'h6a;
    mdl[0] = 8'h82;
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      custom_status_enable <= e[0];
      sw_default <= 16'(rnd());
      sw_req <= 1'b1;
      @(posedge clk);
      sw_req <= 1'b0;
      #1;
      check(sw_rsp.valid, 1'b1);
      check(sw_rsp.word, e[0] ? {mdl[1], mdl[0]} : sw_default);
    end
    for (int f = 0; f < 3; f++) begin
      d = 8'(rnd());
      wr(ADDR_WTX_LO, d);
      ack_dly <= 4'(f * 3);
      @(posedge clk);
      fwi <= 4'(f);
      cmd_start <= 1'b1;
      @(posedge clk);
      cmd_start <= 1'b0;
      #1;
      n = 0;
      while (wtx_req !== 1'b1 && n < 1000) tick();
      check(16'(n), 16'(wait_len(f)));
      check(wtx_inf, d);
      n = 0;
      while (wtx_ack !== 1'b1 && n < 100) tick();
      check(wtx_ack, 1'b1);
      n = 0;
      do tick(); while (wtx_req !== 1'b1 && n < 1000);
      check(16'(n), 16'(wait_len(f) + 1));
      @(posedge clk);
      rsp_done <= 1'b1;
      @(posedge clk);
      rsp_done <= 1'b0;
      #1;
      check(timer_busy, 1'b0);
      repeat (8) @(posedge clk);
    end
    // reset while a command waits: timer and registers fall back
    @(posedge clk);
    fwi <= 4'hf;
    cmd_start <= 1'b1;
    @(posedge clk);
    cmd_start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(timer_busy, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(timer_busy, 1'b0);
    check(file_offset_out, RST_OFS);
    check(buffer_start_out, RST_BUF);
    for (int i = 0; i < 8; i++) begin
      rd(amap[i], d);
      check(d, (i == 2) ? RST_WTX[7:0] : 8'h00);
    end
    report_and_stop();
  end
endmodule  // testbench
